//--- scus_defs.svh
`ifndef SCUS_DEFS_SVH
`define SCUS_DEFS_SVH
`define SCUS_STATUS_ADDR 8'hAD
`define SCUS_STATUS_RESET 8'h80
`define SCUS_BIT_TBE 7
`define SCUS_BIT_CARD 6
`define SCUS_BIT_OVC 5
`define SCUS_BIT_VOK 4
`define SCUS_BIT_WTO 3
`define SCUS_BIT_TC 2
`define SCUS_BIT_RC 1
`define SCUS_BIT_PE 0
`endif

//--- scus_pkg.sv
package scus_pkg;
    typedef struct packed {
        logic tx_load;
        logic tx_done_ok;
        logic tx_final_fail;
        logic rx_done;
        logic rx_parity_bad;
        logic rx_final;
        logic wt_timeout;
        logic wt_reload;
    } scus_evt_t;
endpackage : scus_pkg

//--- scus_status.sv
`timescale 1ns/1ps
`include "scus_defs.svh"
module scus_status (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_rd_in,
    input wire logic register_page_select_in,
    input wire logic uart_data_buffer_wr_in,
    input wire logic uart_data_buffer_rd_in,
    input wire logic rep_mode_in,
    input wire scus_pkg::scus_evt_t evt_in,
    input wire logic card_detect_pin_in,
    input wire logic overcurrent_pin_in,
    input wire logic voltage_in_range_pin_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_hit_out
);
    logic status_sel;
    logic [7:0] stat_q, stat_d;
    logic [2:0] card_s1_q, card_s2_q;

    // Page select gates the decode; ADh on page 1 belongs elsewhere
    assign status_sel = sfr_addr_in == `SCUS_STATUS_ADDR && !register_page_select_in;
    assign sfr_hit_out = status_sel;

    // Analog levels come from other domains; two stages each
    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) begin
            card_s1_q <= 3'h0;
            card_s2_q <= 3'h0;
        end else begin
            card_s1_q <= {card_detect_pin_in, overcurrent_pin_in, voltage_in_range_pin_in};
            card_s2_q <= card_s1_q;
        end
    end

    always_comb begin
        stat_d = stat_q;
        // Set wins over clear in every event flag; CARD, OVC and VOK just copy the synced pins
        if (uart_data_buffer_wr_in) stat_d[`SCUS_BIT_TBE] = 1'b0;
        if (evt_in.tx_load) stat_d[`SCUS_BIT_TBE] = 1'b1;
        stat_d[`SCUS_BIT_CARD] = card_s2_q[2];
        stat_d[`SCUS_BIT_OVC] = card_s2_q[1];
        stat_d[`SCUS_BIT_VOK] = card_s2_q[0];
        if (evt_in.wt_reload) stat_d[`SCUS_BIT_WTO] = 1'b0;
        if (evt_in.wt_timeout) stat_d[`SCUS_BIT_WTO] = 1'b1;
        if (status_sel && sfr_rd_in) begin
            stat_d[`SCUS_BIT_TC] = 1'b0;
            stat_d[`SCUS_BIT_PE] = 1'b0;
        end
        // UART reports tx_done_ok only on success under repetition
        if (evt_in.tx_done_ok) stat_d[`SCUS_BIT_TC] = 1'b1;
        if (uart_data_buffer_rd_in) stat_d[`SCUS_BIT_RC] = 1'b0;
        if (evt_in.rx_done) stat_d[`SCUS_BIT_RC] = 1'b1;
        if (rep_mode_in) begin
            if (evt_in.tx_final_fail || (evt_in.rx_done && evt_in.rx_parity_bad && evt_in.rx_final))
                stat_d[`SCUS_BIT_PE] = 1'b1;
        end else if (evt_in.rx_done && evt_in.rx_parity_bad) begin
            stat_d[`SCUS_BIT_PE] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge nrst_in) begin
        if (!nrst_in) stat_q <= `SCUS_STATUS_RESET;
        else stat_q <= stat_d;
    end

    assign sfr_rdata_out = status_sel ? stat_q : 8'h00;

    a_tbe_set: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        evt_in.tx_load |=> stat_q[`SCUS_BIT_TBE]) else $error("tbe not set");
    a_tbe_clr: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        uart_data_buffer_wr_in && !evt_in.tx_load |=> !stat_q[`SCUS_BIT_TBE]) else $error("tbe not cleared");
    a_rd_clears: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        status_sel && sfr_rd_in && !evt_in.tx_done_ok && !evt_in.rx_done && !evt_in.tx_final_fail
        |=> !stat_q[`SCUS_BIT_TC] && !stat_q[`SCUS_BIT_PE]) else $error("read clear failed");
    a_rc_set: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        evt_in.rx_done |=> stat_q[`SCUS_BIT_RC]) else $error("rc not set");
    a_rc_clr: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        uart_data_buffer_rd_in && !evt_in.rx_done |=> !stat_q[`SCUS_BIT_RC]) else $error("rc not cleared");
    a_wto_flag: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        evt_in.wt_timeout |=> stat_q[`SCUS_BIT_WTO]) else $error("wto not set");
    a_pe_rep: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        rep_mode_in && !evt_in.tx_final_fail && !evt_in.rx_final && !stat_q[`SCUS_BIT_PE]
        |=> !stat_q[`SCUS_BIT_PE]) else $error("pe set early");
    a_card_track: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        card_s2_q[2] |=> stat_q[`SCUS_BIT_CARD]) else $error("card flag lag");
    a_page_gate: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
        register_page_select_in |-> sfr_rdata_out == 8'h00 && !sfr_hit_out) else $error("page leak");
    c_tx_done: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) evt_in.tx_done_ok);
    c_rx_parity: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) evt_in.rx_done && evt_in.rx_parity_bad);
    c_status_read: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) status_sel && sfr_rd_in);
    c_rep_final: cover property (@(posedge clk_sys_in) disable iff (!nrst_in) rep_mode_in && evt_in.tx_final_fail);
endmodule : scus_status

//--- scus_card_model.sv
`timescale 1ns/1ps
module scus_card_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] evt_req_in,
    input wire logic [2:0] pins_req_in,
    output scus_pkg::scus_evt_t evt_out,
    output logic [2:0] pins_out
);
    // Card side events are single-cycle pulses; contact levels move slowly
    always_ff @(posedge clk_sys_in) begin
        evt_out <= evt_req_in;
        pins_out <= pins_req_in;
    end
endmodule : scus_card_model

//--- smart_card_uart_status_flags_bench.sv
`timescale 1ns/1ps
module smart_card_uart_status_flags_bench;
    logic clk_sys_in, nrst_in, rd, pg, dbw, dbr, rep, hit;
    logic [7:0] addr, ereq, rdata;
    logic [2:0] preq, pins;
    logic [8:0] d;
    scus_pkg::scus_evt_t evt;
    int bad_count, check_count, cyc;
    scus_card_model u_card (.clk_sys_in(clk_sys_in), .evt_req_in(ereq), .pins_req_in(preq), .evt_out(evt),
        .pins_out(pins));
    scus_status u_dut (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sfr_addr_in(addr), .sfr_rd_in(rd),
        .register_page_select_in(pg), .uart_data_buffer_wr_in(dbw), .uart_data_buffer_rd_in(dbr),
        .rep_mode_in(rep), .evt_in(evt), .card_detect_pin_in(pins[2]), .overcurrent_pin_in(pins[1]),
        .voltage_in_range_pin_in(pins[0]), .sfr_rdata_out(rdata), .sfr_hit_out(hit));
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value hit_and_status expected %h seen %h", exp, seen);
        end
    endtask : check
    task automatic rd_sfr(input logic [7:0] a, input logic p);
        @(posedge clk_sys_in);
        addr <= a;
        pg <= p;
        rd <= 1'b1;
        #1 d = {hit, rdata};
        @(posedge clk_sys_in);
        rd <= 1'b0;
    endtask : rd_sfr
    task automatic sts(input logic [7:0] exp);
        rd_sfr(8'hAD, 1'b0);
        check(d, {1'b1, exp});
    endtask : sts
    task automatic pulse(input logic [7:0] e, input logic w, input logic r);
        @(posedge clk_sys_in);
        ereq <= e;
        dbw <= w;
        dbr <= r;
        @(posedge clk_sys_in);
        ereq <= 8'h00;
        dbw <= 1'b0;
        dbr <= 1'b0;
    endtask : pulse
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // Ceiling far above the roughly 100 cycles the sequence needs
    always @(posedge clk_sys_in) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            give_verdict();
        end
    end
    initial begin
        {nrst_in, rd, pg, dbw, dbr, rep, addr, ereq, preq} = '0;
        repeat (12) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        sts(8'h80);
        rd_sfr(8'hAD, 1'b1); check(d, 9'h000);
        rd_sfr(8'hAC, 1'b0); check(d, 9'h000);
        pulse(8'h00, 1'b1, 1'b0); sts(8'h00);
        pulse(8'h80, 1'b0, 1'b0); sts(8'h80);
        preq <= 3'h7; repeat (5) @(posedge clk_sys_in); sts(8'hF0);
        preq <= 3'h6; repeat (5) @(posedge clk_sys_in); sts(8'hE0);
        pulse(8'h02, 1'b0, 1'b0); sts(8'hE8);
        pulse(8'h01, 1'b0, 1'b0); sts(8'hE0);
        pulse(8'h40, 1'b0, 1'b0); pulse(8'h18, 1'b0, 1'b0); sts(8'hE7);
        sts(8'hE2);
        pulse(8'h00, 1'b0, 1'b1); sts(8'hE0);
        rep <= 1'b1;
        pulse(8'h18, 1'b0, 1'b0); sts(8'hE2);
        pulse(8'h20, 1'b0, 1'b0); sts(8'hE3);
        pulse(8'h00, 1'b0, 1'b1); pulse(8'h1C, 1'b0, 1'b0); sts(8'hE3);
        pulse(8'h40, 1'b0, 1'b0); sts(8'hE6);
        // Refused reads must leave the read-clear TC flag alone
        pulse(8'h40, 1'b0, 1'b0);
        rd_sfr(8'hAD, 1'b1); check(d, 9'h000);
        rd_sfr(8'hAC, 1'b0); check(d, 9'h000);
        sts(8'hE6);
        // Mid-run reset; pins stay up, so flags return only after the sync stages
        @(posedge clk_sys_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        nrst_in <= 1'b1;
        sts(8'h80);
        repeat (5) @(posedge clk_sys_in);
        sts(8'hE0);
        give_verdict();
    end
endmodule : smart_card_uart_status_flags_bench
